// >>> verilog/triple_fifo_pkg.sv
// Shared constants for the triple-port queue and mailbox block.
package triple_fifo_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned LONG_W      = 36;
  localparam int unsigned NARROW_W    = 18;
  localparam int unsigned BYTE_W      = 9;
  localparam int unsigned COUNT_W     = 11;
  localparam int unsigned WIDE_SYNC_W = 41;
  localparam int unsigned TX_SYNC_W   = 4;
  localparam int unsigned RX_SYNC_W   = 21;
  localparam int unsigned CFG_SYNC_W  = 3;

  // ==========================================================================
  // Queue depth default, one of 256, 512 or 1,024 long words.
  localparam int unsigned DEPTH_DEFAULT = 1024;

  // ==========================================================================
  // Partial flag offsets in long words.
  localparam logic [COUNT_W-1:0] ALMOST_EMPTY_OFFSET = 11'h008;
  localparam logic [COUNT_W-1:0] ALMOST_FULL_OFFSET  = 11'h008;

  // ==========================================================================
  // Lane counter limits for byte and word sizing.
  localparam logic [1:0] LAST_BYTE_LANE = 2'h3;
  localparam logic [1:0] LAST_WORD_LANE = 2'h1;
  localparam logic [1:0] FIRST_LANE     = 2'h0;

  // ==========================================================================
  // Values after reset.
  localparam logic FULL_N_RESET    = 1'b0;
  localparam logic IREADY_RESET    = 1'b0;
  localparam logic AEMPTY_N_RESET  = 1'b0;
  localparam logic AFULL_N_RESET   = 1'b1;
  localparam logic MBX_FULL_N_RESET = 1'b1;

endpackage

// >>> verilog/pin_sync.sv
// Two flip-flop synchroniser for a group of pins from outside the clock's domain.
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Pins in, synchronised copy out.
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // ==========================================================================
  // The first stage feeds only the second stage, never any logic.
  // Both stages keep sampling through reset, so a level latched while reset is
  // held is the pin's real level and not a cleared zero.
  always_ff @(posedge sys_clk) begin
    meta_reg   <= din;
    stable_reg <= meta_reg;
  end

  assign dout = stable_reg;

endmodule // pin_sync

// >>> verilog/long_word_queue.sv
// Storage of 36-bit long words with push, pop and a fill count.
module long_word_queue
  import triple_fifo_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEFAULT
) (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Write side.
  input  wire logic               push,
  input  wire logic [LONG_W-1:0]  push_data,
  // Read side.
  input  wire logic               pop,
  output logic      [LONG_W-1:0]  head_data,
  output logic      [COUNT_W-1:0] count
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [COUNT_W-1:0] DEPTH_C = COUNT_W'(DEPTH);

  logic [LONG_W-1:0]  mem [DEPTH];
  logic [PTR_W-1:0]   wr_ptr_reg;
  logic [PTR_W-1:0]   wr_ptr_next;
  logic [PTR_W-1:0]   rd_ptr_reg;
  logic [PTR_W-1:0]   rd_ptr_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               push_ok;
  logic               pop_ok;

  // ==========================================================================
  // Pointers wrap naturally because every depth is a power of two.
  always_comb begin
    push_ok     = push && (count_reg != DEPTH_C);
    pop_ok      = pop && (count_reg != '0);
    wr_ptr_next = push_ok ? PTR_W'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
    rd_ptr_next = pop_ok ? PTR_W'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next  = COUNT_W'(count_reg + COUNT_W'(push_ok) - COUNT_W'(pop_ok));
  end

  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Memory is written without reset; unread words carry no meaning.
  always_ff @(posedge sys_clk) begin
    if (push_ok) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  assign head_data = mem[rd_ptr_reg];
  assign count     = count_reg;

endmodule // long_word_queue

// >>> verilog/triple_port_fifo.sv
// Top of the triple-port queue pair with flag timing and mailboxes.
// What this block does
// - Forward full flag rises next wide edge
// - Forward full frees only after last lane
// - Return full flag rises next receive edge
// - Return full drops only on final lane
// - Forward almost-empty rises next transmit edge
// - Forward almost-empty drops on final lane
// - Return almost-empty rises next wide edge
// - Return almost-empty counts only completed words
// - Forward almost-full rises next wide edge
// - Forward almost-full counts only final lane
// - Return almost-full rises next receive edge
// - Return almost-full drops on final lane
// - Depth is 256, 512 or 1,024
// - Word size: forward mailbox carries bits 0-17
// - Byte size: forward mailbox carries bits 0-8
// - Word size: return mail on wide 18-35
// - Byte size: return mail on wide 18-26
// - Endian latched at reset orders lanes
module triple_port_fifo
  import triple_fifo_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEFAULT
) (
  // System clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Wide bidirectional port.
  input  wire logic                wide_port_clock,
  input  wire logic                wide_port_select_n,
  input  wire logic                wide_port_direction,
  input  wire logic                wide_port_mail_select,
  input  wire logic                wide_port_enable,
  input  wire logic [LONG_W-1:0]   wide_port_data_in,
  output logic      [LONG_W-1:0]   wide_port_data_out,
  output logic                     wide_port_data_oe,
  output logic                     fwd_queue_full_n,
  output logic                     fwd_queue_input_ready,
  output logic                     fwd_almost_full_n,
  output logic                     ret_almost_empty_n,
  output logic                     fwd_mailbox_full_n,
  // Transmit port.
  input  wire logic                tx_port_clock,
  input  wire logic                tx_port_select_n,
  input  wire logic                tx_port_mail_select,
  input  wire logic                tx_port_read_enable,
  output logic      [NARROW_W-1:0] tx_port_data,
  output logic                     fwd_almost_empty_n,
  // Receive port.
  input  wire logic                rx_port_clock,
  input  wire logic                rx_port_mail_select,
  input  wire logic                rx_port_write_enable,
  input  wire logic [NARROW_W-1:0] rx_port_data,
  output logic                     ret_queue_full_n,
  output logic                     ret_queue_input_ready,
  output logic                     ret_almost_full_n,
  output logic                     ret_mailbox_full_n,
  // Static configuration.
  input  wire logic                tx_port_byte_size,
  input  wire logic                rx_port_byte_size,
  input  wire logic                endian_select
);

  localparam logic [COUNT_W-1:0] DEPTH_C = COUNT_W'(DEPTH);
  localparam logic [COUNT_W-1:0] AF_LIMIT = COUNT_W'(DEPTH_C - ALMOST_FULL_OFFSET);

  // ==========================================================================
  // Lane helpers. Lane 0 is the most significant byte or word of a long word.
  function automatic logic [NARROW_W-1:0] take_lane(input logic [LONG_W-1:0] w,
                                                     input logic [1:0] idx,
                                                     input logic byte_mode);
    logic [NARROW_W-1:0] r;
    r = '0;
    if (byte_mode) begin
      r = {9'h000, w[(35 - 9 * idx) -: 9]};
    end else begin
      r = w[(35 - 18 * idx[0]) -: 18];
    end
    return r;
  endfunction

  function automatic logic [LONG_W-1:0] put_lane(input logic [LONG_W-1:0] w,
                                                 input logic [1:0] idx,
                                                 input logic byte_mode,
                                                 input logic [NARROW_W-1:0] v);
    logic [LONG_W-1:0] r;
    r = w;
    if (byte_mode) begin
      r[(35 - 9 * idx) -: 9] = v[8:0];
    end else begin
      r[(35 - 18 * idx[0]) -: 18] = v;
    end
    return r;
  endfunction

  // ==========================================================================
  // Pin synchronisers; every port clock is just another sampled input.
  logic [WIDE_SYNC_W-1:0] wide_s;
  logic [TX_SYNC_W-1:0]   tx_s;
  logic [RX_SYNC_W-1:0]   rx_s;
  logic [CFG_SYNC_W-1:0]  cfg_s;

  pin_sync #(.WIDTH(WIDE_SYNC_W)) wide_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({wide_port_clock, wide_port_select_n, wide_port_direction,
               wide_port_mail_select, wide_port_enable, wide_port_data_in}),
    .dout    (wide_s)
  );
  pin_sync #(.WIDTH(TX_SYNC_W)) tx_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({tx_port_clock, tx_port_select_n, tx_port_mail_select, tx_port_read_enable}),
    .dout    (tx_s)
  );
  pin_sync #(.WIDTH(RX_SYNC_W)) rx_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({rx_port_clock, rx_port_mail_select, rx_port_write_enable, rx_port_data}),
    .dout    (rx_s)
  );
  pin_sync #(.WIDTH(CFG_SYNC_W)) cfg_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({tx_port_byte_size, rx_port_byte_size, endian_select}),
    .dout    (cfg_s)
  );

  // Size selects are sampled live; they are expected never to move.
  logic tx_byte;
  logic rx_byte;
  assign tx_byte = cfg_s[2];
  assign rx_byte = cfg_s[1];

  // ==========================================================================
  // Edge finding on the synchronised port clocks.
  logic wide_clk_prev_reg;
  logic tx_clk_prev_reg;
  logic rx_clk_prev_reg;
  logic endian_big_reg;
  logic wide_edge;
  logic tx_edge;
  logic rx_edge;

  assign wide_edge = wide_s[40] & ~wide_clk_prev_reg;
  assign tx_edge   = tx_s[3] & ~tx_clk_prev_reg;
  assign rx_edge   = rx_s[20] & ~rx_clk_prev_reg;

  // Endian choice is held from reset and ignores later pin changes.
  // The previous levels track through reset, so a clock that is high at
  // release does not show a false edge.
  always_ff @(posedge sys_clk) begin
    wide_clk_prev_reg <= wide_s[40];
    tx_clk_prev_reg   <= tx_s[3];
    rx_clk_prev_reg   <= rx_s[20];
    if (reset) begin
      endian_big_reg <= cfg_s[0];
    end
  end

  // ==========================================================================
  // The two queues.
  logic                fwd_push;
  logic                fwd_pop;
  logic                ret_push;
  logic                ret_pop;
  logic [LONG_W-1:0]   fwd_head;
  logic [LONG_W-1:0]   ret_head;
  logic [COUNT_W-1:0]  fwd_count;
  logic [COUNT_W-1:0]  ret_count;
  logic [LONG_W-1:0]   ret_word;

  long_word_queue #(.DEPTH(DEPTH)) forward_queue (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (fwd_push),
    .push_data (wide_s[35:0]),
    .pop       (fwd_pop),
    .head_data (fwd_head),
    .count     (fwd_count)
  );
  long_word_queue #(.DEPTH(DEPTH)) return_queue (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (ret_push),
    .push_data (ret_word),
    .pop       (ret_pop),
    .head_data (ret_head),
    .count     (ret_count)
  );

  // ==========================================================================
  // Port state registers.
  logic [LONG_W-1:0]   wide_out_reg,  wide_out_next;
  logic                wide_oe_reg,   wide_oe_next;
  logic [NARROW_W-1:0] tx_out_reg,    tx_out_next;
  logic [1:0]          tx_lane_reg,   tx_lane_next;
  logic [1:0]          rx_lane_reg,   rx_lane_next;
  logic [LONG_W-1:0]   rx_asm_reg,    rx_asm_next;
  logic [NARROW_W-1:0] fwd_mbx_reg,   fwd_mbx_next;
  logic [NARROW_W-1:0] ret_mbx_reg,   ret_mbx_next;
  logic                fwd_mbf_reg,   fwd_mbf_next;
  logic                ret_mbf_reg,   ret_mbf_next;
  logic                fwd_ff_reg,    fwd_ff_next;
  logic                fwd_af_reg,    fwd_af_next;
  logic                fwd_ae_reg,    fwd_ae_next;
  logic                ret_ff_reg,    ret_ff_next;
  logic                ret_af_reg,    ret_af_next;
  logic                ret_ae_reg,    ret_ae_next;
  logic [1:0]          tx_last;
  logic [1:0]          rx_last;
  logic [1:0]          tx_idx;
  logic [1:0]          rx_idx;
  logic                fwd_mb_wr;
  logic                fwd_mb_rd;
  logic                ret_mb_wr;
  logic                ret_mb_rd;
  logic                tx_lane_rd;
  logic                rx_lane_wr;
  logic [COUNT_W-1:0]  fwd_level;
  logic [COUNT_W-1:0]  ret_level;

  // Port decodes. Writes are refused while the matching full flag is low.
  always_comb begin
    tx_last    = tx_byte ? LAST_BYTE_LANE : LAST_WORD_LANE;
    rx_last    = rx_byte ? LAST_BYTE_LANE : LAST_WORD_LANE;
    tx_idx     = endian_big_reg ? tx_lane_reg : 2'(tx_last - tx_lane_reg);
    rx_idx     = endian_big_reg ? rx_lane_reg : 2'(rx_last - rx_lane_reg);
    fwd_push   = wide_edge & ~wide_s[39] & wide_s[38] & ~wide_s[37] & wide_s[36]
                 & fwd_ff_reg;
    ret_pop    = wide_edge & ~wide_s[39] & ~wide_s[38] & ~wide_s[37] & wide_s[36]
                 & (ret_count != '0);
    fwd_mb_wr  = wide_edge & ~wide_s[39] & wide_s[38] & wide_s[37] & wide_s[36];
    ret_mb_rd  = wide_edge & ~wide_s[39] & ~wide_s[38] & wide_s[37] & wide_s[36];
    tx_lane_rd = tx_edge & ~tx_s[2] & ~tx_s[1] & tx_s[0] & (fwd_count != '0);
    fwd_mb_rd  = tx_edge & ~tx_s[2] & tx_s[1] & tx_s[0];
    rx_lane_wr = rx_edge & ~rx_s[19] & rx_s[18] & ret_ff_reg;
    ret_mb_wr  = rx_edge & rx_s[19] & rx_s[18];
    fwd_pop    = tx_lane_rd & (tx_lane_reg == tx_last);
    ret_push   = rx_lane_wr & (rx_lane_reg == rx_last);
    ret_word   = put_lane(rx_asm_reg, rx_idx, rx_byte, rx_s[17:0]);
    fwd_level  = COUNT_W'(fwd_count + COUNT_W'(fwd_push) - COUNT_W'(fwd_pop));
    ret_level  = COUNT_W'(ret_count + COUNT_W'(ret_push) - COUNT_W'(ret_pop));
  end

  // ==========================================================================
  // Next state. Each queue flag moves only on its own port's clock edge, so a level
  // change seen just before that edge waits for it; one late port edge is the
  // skew penalty.
  always_comb begin
    wide_out_next = wide_out_reg;
    wide_oe_next  = wide_oe_reg;
    tx_out_next   = tx_out_reg;
    tx_lane_next  = tx_lane_reg;
    rx_lane_next  = rx_lane_reg;
    rx_asm_next   = rx_asm_reg;
    fwd_mbx_next  = fwd_mbx_reg;
    ret_mbx_next  = ret_mbx_reg;
    fwd_mbf_next  = fwd_mbf_reg;
    ret_mbf_next  = ret_mbf_reg;
    fwd_ff_next   = fwd_ff_reg;
    fwd_af_next   = fwd_af_reg;
    fwd_ae_next   = fwd_ae_reg;
    ret_ff_next   = ret_ff_reg;
    ret_af_next   = ret_af_reg;
    ret_ae_next   = ret_ae_reg;
    if (wide_edge) begin
      wide_oe_next = ~wide_s[39] & ~wide_s[38];
      fwd_ff_next  = fwd_level < DEPTH_C;
      fwd_af_next  = fwd_level < AF_LIMIT;
      ret_ae_next  = ret_level > ALMOST_EMPTY_OFFSET;
    end
    if (ret_pop) begin
      wide_out_next = ret_head;
    end
    // Return mail lands in the upper half; unused bits are driven as zero.
    if (ret_mb_rd) begin
      wide_out_next = {ret_mbx_reg, 18'h0_0000};
      ret_mbf_next  = 1'b1;
    end
    if (ret_mb_wr && ret_mbf_reg) begin
      ret_mbx_next = rx_byte ? {9'h000, rx_s[8:0]} : rx_s[17:0];
      ret_mbf_next = 1'b0;
    end
    if (tx_edge) begin
      fwd_ae_next = fwd_level > ALMOST_EMPTY_OFFSET;
    end
    if (tx_lane_rd) begin
      tx_out_next  = take_lane(fwd_head, tx_idx, tx_byte);
      tx_lane_next = fwd_pop ? FIRST_LANE : 2'(tx_lane_reg + 1'b1);
    end
    if (fwd_mb_rd) begin
      tx_out_next  = fwd_mbx_reg;
      fwd_mbf_next = 1'b1;
    end
    // A mailbox write in the same cycle as a read of it wins.
    if (fwd_mb_wr && fwd_mbf_reg) begin
      fwd_mbx_next = tx_byte ? {9'h000, wide_s[8:0]} : wide_s[17:0];
      fwd_mbf_next = 1'b0;
    end
    if (rx_edge) begin
      ret_ff_next = ret_level < DEPTH_C;
      ret_af_next = ret_level < AF_LIMIT;
    end
    if (rx_lane_wr) begin
      rx_asm_next  = ret_word;
      rx_lane_next = ret_push ? FIRST_LANE : 2'(rx_lane_reg + 1'b1);
    end
  end

  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wide_out_reg <= '0;
      wide_oe_reg  <= 1'b0;
      tx_out_reg   <= '0;
      tx_lane_reg  <= FIRST_LANE;
      rx_lane_reg  <= FIRST_LANE;
      rx_asm_reg   <= '0;
      fwd_mbx_reg  <= '0;
      ret_mbx_reg  <= '0;
      fwd_mbf_reg  <= MBX_FULL_N_RESET;
      ret_mbf_reg  <= MBX_FULL_N_RESET;
      fwd_ff_reg   <= FULL_N_RESET;
      fwd_af_reg   <= AFULL_N_RESET;
      fwd_ae_reg   <= AEMPTY_N_RESET;
      ret_ff_reg   <= FULL_N_RESET;
      ret_af_reg   <= AFULL_N_RESET;
      ret_ae_reg   <= AEMPTY_N_RESET;
    end else begin
      wide_out_reg <= wide_out_next;
      wide_oe_reg  <= wide_oe_next;
      tx_out_reg   <= tx_out_next;
      tx_lane_reg  <= tx_lane_next;
      rx_lane_reg  <= rx_lane_next;
      rx_asm_reg   <= rx_asm_next;
      fwd_mbx_reg  <= fwd_mbx_next;
      ret_mbx_reg  <= ret_mbx_next;
      fwd_mbf_reg  <= fwd_mbf_next;
      ret_mbf_reg  <= ret_mbf_next;
      fwd_ff_reg   <= fwd_ff_next;
      fwd_af_reg   <= fwd_af_next;
      fwd_ae_reg   <= fwd_ae_next;
      ret_ff_reg   <= ret_ff_next;
      ret_af_reg   <= ret_af_next;
      ret_ae_reg   <= ret_ae_next;
    end
  end

  // Input-ready shares the full flag's timing in this build.
  assign wide_port_data_out    = wide_out_reg;
  assign wide_port_data_oe     = wide_oe_reg;
  assign fwd_queue_full_n      = fwd_ff_reg;
  assign fwd_queue_input_ready = fwd_ff_reg;
  assign fwd_almost_full_n     = fwd_af_reg;
  assign ret_almost_empty_n    = ret_ae_reg;
  assign fwd_mailbox_full_n    = fwd_mbf_reg;
  assign tx_port_data          = tx_out_reg;
  assign fwd_almost_empty_n    = fwd_ae_reg;
  assign ret_queue_full_n      = ret_ff_reg;
  assign ret_queue_input_ready = ret_ff_reg;
  assign ret_almost_full_n     = ret_af_reg;
  assign ret_mailbox_full_n    = ret_mbf_reg;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_fwd_mail_write;
    fwd_mb_wr && fwd_mbf_reg;
  endsequence

  chk_fwd_full_rise: assert property (wide_edge && fwd_level < DEPTH_C |=> fwd_queue_full_n)
    else $error("forward full flag did not rise on wide edge");
  chk_fwd_full_hold: assert property (!wide_edge |=> $stable(fwd_queue_full_n))
    else $error("forward full flag moved off a wide edge");
  chk_ret_full_rise: assert property (rx_edge && ret_level < DEPTH_C |=> ret_queue_full_n)
    else $error("return full flag did not rise on receive edge");
  chk_ret_full_lane: assert property (rx_lane_wr && !ret_push && !ret_pop
                                      |=> $stable(ret_count))
    else $error("return queue filled before last lane");
  chk_fwd_ae_rise: assert property (tx_edge && fwd_level > ALMOST_EMPTY_OFFSET
                                    |=> fwd_almost_empty_n)
    else $error("forward almost-empty did not rise");
  chk_ret_ae_rise: assert property (wide_edge && ret_level > ALMOST_EMPTY_OFFSET
                                    |=> ret_almost_empty_n)
    else $error("return almost-empty did not rise");
  chk_fwd_af_rise: assert property (wide_edge && fwd_level < AF_LIMIT
                                    |=> fwd_almost_full_n)
    else $error("forward almost-full did not rise");
  chk_ret_af_drop: assert property (rx_edge && ret_level >= AF_LIMIT
                                    |=> !ret_almost_full_n)
    else $error("return almost-full did not fall");
  chk_fwd_mail_flag: assert property (s_fwd_mail_write |=> !fwd_mailbox_full_n
                                      ##1 (fwd_mailbox_full_n == $past(fwd_mb_rd)))
    else $error("forward mailbox flag did not fall on write");
  chk_tx_mail_data: assert property (fwd_mb_rd && !fwd_mb_wr && !tx_byte
                                     |=> tx_port_data == $past(fwd_mbx_reg))
    else $error("transmit port did not show forward mail");

endmodule // triple_port_fifo

// >>> dv/port_masters.sv
// Far-side port masters: the three free-running port clocks.
module port_masters (
  // Port clocks: bit 0 wide, bit 1 transmit, bit 2 receive.
  output logic [2:0] pc
);
  timeunit 1ns;
  timeprecision 100ps;
  // Odd start offsets keep the port clocks unrelated in phase to sys_clk and each other.
  initial begin
    pc = 3'h0;
    fork
      begin #3; forever #80 pc[0] = ~pc[0]; end
      begin #41; forever #80 pc[1] = ~pc[1]; end
      begin #77; forever #80 pc[2] = ~pc[2]; end
    join
  end
endmodule // port_masters

// >>> dv/triple_port_fifo_tb.sv
// Self-checking bench for the triple-port queue and mailbox block.
module triple_port_fifo_tb
  import triple_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Signals
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic [2:0]        pc;
  logic              wide_port_select_n = 1'b1, wide_port_direction = 1'b0;
  logic              wide_port_mail_select = 1'b0, wide_port_enable = 1'b0;
  logic [LONG_W-1:0] wide_port_data_in = '0, wide_port_data_out;
  logic              wide_port_data_oe, fwd_queue_full_n, fwd_queue_input_ready;
  logic              fwd_almost_full_n, ret_almost_empty_n, fwd_mailbox_full_n;
  logic              tx_port_select_n = 1'b1, tx_port_mail_select = 1'b0;
  logic              tx_port_read_enable = 1'b0, fwd_almost_empty_n;
  logic [17:0]       tx_port_data, rx_port_data = '0;
  logic              rx_port_mail_select = 1'b0, rx_port_write_enable = 1'b0;
  logic              ret_queue_full_n, ret_queue_input_ready, ret_almost_full_n;
  logic              ret_mailbox_full_n;
  logic              tx_port_byte_size = 1'b0, rx_port_byte_size = 1'b0;
  logic              endian_select = 1'b1;
  int                failures = 0, tests_run = 0;

  port_masters far_side (.pc(pc));
  // A short depth keeps the fill and drain of the forward queue cheap.
  triple_port_fifo #(.DEPTH(256)) dut (
    .sys_clk, .reset, .wide_port_clock(pc[0]), .wide_port_select_n, .wide_port_direction,
    .wide_port_mail_select, .wide_port_enable, .wide_port_data_in, .wide_port_data_out,
    .wide_port_data_oe, .fwd_queue_full_n, .fwd_queue_input_ready, .fwd_almost_full_n,
    .ret_almost_empty_n, .fwd_mailbox_full_n, .tx_port_clock(pc[1]), .tx_port_select_n,
    .tx_port_mail_select, .tx_port_read_enable, .tx_port_data, .fwd_almost_empty_n,
    .rx_port_clock(pc[2]), .rx_port_mail_select, .rx_port_write_enable, .rx_port_data,
    .ret_queue_full_n, .ret_queue_input_ready, .ret_almost_full_n, .ret_mailbox_full_n,
    .tx_port_byte_size, .rx_port_byte_size, .endian_select);

  always #4 sys_clk = ~sys_clk;

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // One transfer on port p; controls stand from falling edge to falling edge of its clock.
  task automatic xfer(input int p, input logic dir, input logic m, input logic [35:0] d);
    @(negedge pc[p]);
    @(posedge sys_clk);
    case (p)
      0: begin
        wide_port_select_n <= 1'b0;
        wide_port_direction <= dir;
        wide_port_mail_select <= m;
        wide_port_enable <= 1'b1;
        wide_port_data_in <= d;
      end
      1: begin
        tx_port_select_n <= 1'b0;
        tx_port_mail_select <= m;
        tx_port_read_enable <= 1'b1;
      end
      default: begin
        rx_port_mail_select <= m;
        rx_port_write_enable <= 1'b1;
        rx_port_data <= d[17:0];
      end
    endcase
    @(posedge pc[p]);
    @(negedge pc[p]);
    @(posedge sys_clk);
    // Released data lines show a changing pattern, never the last value.
    wide_port_select_n <= 1'b1;
    wide_port_enable <= 1'b0;
    tx_port_select_n <= 1'b1;
    tx_port_read_enable <= 1'b0;
    rx_port_write_enable <= 1'b0;
    wide_port_data_in <= ~wide_port_data_in;
    rx_port_data <= ~rx_port_data;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic mail_test;
    xfer(0, 1'b1, 1'b1, 36'h5_1234_5678);
    chk(fwd_mailbox_full_n === 1'b0, "fwd mail flag not set");
    xfer(1, 1'b0, 1'b1, '0);
    chk(tx_port_data === 18'h0_5678, "fwd mail data");
    chk(fwd_mailbox_full_n === 1'b1, "fwd mail flag not cleared");
    xfer(2, 1'b0, 1'b1, 36'h0_0002_A5C3);
    chk(ret_mailbox_full_n === 1'b0, "ret mail flag not set");
    xfer(0, 1'b0, 1'b1, '0);
    chk(wide_port_data_out[35:18] === 18'h2_A5C3, "ret mail data");
    chk(wide_port_data_oe === 1'b1, "wide bus not driven on read");
    chk(ret_mailbox_full_n === 1'b1, "ret mail flag not cleared");
  endtask

  task automatic ret_queue_test;
    xfer(2, 1'b0, 1'b0, 36'h0_0003_0F0F);
    xfer(2, 1'b0, 1'b0, 36'h0_0000_F0F0);
    chk(ret_queue_full_n & ret_queue_input_ready & ret_almost_full_n & ~ret_almost_empty_n,
        "ret flags after one long word");
    xfer(0, 1'b0, 1'b0, '0);
    chk(wide_port_data_out === 36'hC_3C3C_F0F0, "ret queue long word");
  endtask

  task automatic fill_drain;
    for (int i = 0; i < 256; i++) xfer(0, 1'b1, 1'b0, {18'(i + 1), 18'(i)});
    repeat (60) @(posedge sys_clk);
    chk(fwd_queue_full_n === 1'b0, "fwd not full");
    chk(fwd_queue_input_ready === 1'b0, "fwd input ready high");
    chk(fwd_almost_full_n === 1'b0, "fwd not almost full");
    chk(fwd_almost_empty_n === 1'b1, "fwd almost empty");
    for (int i = 0; i < 256; i++) begin
      xfer(1, 1'b0, 1'b0, '0);
      chk(tx_port_data === 18'(i + 1), "tx upper lane");
      if (i == 0) chk(fwd_queue_full_n === 1'b0, "full freed mid word");
      if (i == 247) chk(fwd_almost_empty_n === 1'b1, "ae fell mid word");
      xfer(1, 1'b0, 1'b0, '0);
      chk(tx_port_data === 18'(i), "tx lower lane");
      if (i == 247) chk(fwd_almost_empty_n === 1'b0, "ae not low");
      if (i == 0 || i == 8) begin
        repeat (2) @(posedge pc[0]);
        repeat (6) @(posedge sys_clk);
        chk(fwd_queue_full_n === 1'b1, "full not freed");
        chk(fwd_almost_full_n === 1'(i == 8), "almost full level");
      end
    end
  endtask

  // Byte sizing and little-endian order are static, so they need a second reset.
  task automatic byte_test;
    logic [35:0] w = 36'h1_2345_6789;
    reset <= 1'b1;
    tx_port_byte_size <= 1'b1;
    rx_port_byte_size <= 1'b1;
    endian_select <= 1'b0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (48) @(posedge sys_clk);
    xfer(0, 1'b1, 1'b0, w);
    for (int n = 0; n < 4; n++) begin
      xfer(1, 1'b0, 1'b0, '0);
      chk(tx_port_data === {9'h000, w[9 * n +: 9]}, "tx byte lane");
    end
    xfer(0, 1'b1, 1'b1, 36'h0_0000_01A5);
    xfer(1, 1'b0, 1'b1, '0);
    chk(tx_port_data[8:0] === 9'h1A5, "fwd byte mail");
    xfer(2, 1'b0, 1'b1, 36'h0_0003_FF5A);
    xfer(0, 1'b0, 1'b1, '0);
    chk(wide_port_data_out[26:18] === 9'h15A, "ret byte mail");
  endtask

  // ==========================================================================
  // Verdict and sequence
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (48) @(posedge sys_clk);
    mail_test();
    ret_queue_test();
    fill_drain();
    byte_test();
    end_of_test();
  end

  // The whole run needs about 260 us; more than twice that means a hang.
  initial begin
    #600_000;
    failures++;
    end_of_test();
  end
endmodule // triple_port_fifo_tb
